/* rtl/step_math_datapath.v */
// Purpose: step-math and store-literal execution datapath, axi4-lite access
// Assumes: single clock, pstack_data comes from logic on sys_clk
// Notes:   writing the instruction register executes one instruction
//
// Register access over AXI4-Lite and the register addresses were chosen for this implementation.
`include "step_math_defines.vh"

module step_math_datapath (
	input  wire        sys_clk,
	input  wire        rst_b,
	input  wire        ce,
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire [15:0] pstack_data,
	output reg         pstack_pop,
	output reg         mem_we,
	output reg  [15:0] mem_addr,
	output reg  [15:0] mem_wdata,
	output reg         ret_pulse
);

	localparam [1:0] S_IDLE = 2'h0;
	localparam [1:0] S_EXEC = 2'h1;
	localparam [1:0] S_ST2  = 2'h2;
	reg  [1:0]  state_q;
	reg  [15:0] ir_q;
	reg  [15:0] top_q;
	reg  [15:0] next_q;
	reg  [15:0] math_operand_reg_q;
	reg  [15:0] shift_remainder_reg_q;
	reg         ext_bit_low_q;
	reg         ext_bit_high_q;
	reg         cond_flag_q;
	reg         aw_have_q;
	reg  [7:0]  aw_addr_q;
	reg         w_have_q;
	reg  [31:0] w_data_q;

	function [15:0] alu16;
		input [2:0]  fn;
		input [15:0] a;
		input [15:0] b;
		begin
			case (fn)
				`F_AND:  alu16 = a & b;
				`F_SUB:  alu16 = a - b;
				`F_OR:   alu16 = a | b;
				`F_ADD:  alu16 = a + b;
				`F_XOR:  alu16 = a ^ b;
				`F_ANDN: alu16 = a & ~b;
				`F_LOAD: alu16 = b;
				default: alu16 = a;
			endcase
		end
	endfunction

	function mapped;
		input [7:0] addr;
		begin
			mapped = (addr == `A_INSTR) || (addr == `A_TOP) ||
				(addr == `A_NEXT) || (addr == `A_MATH) ||
				(addr == `A_REM) || (addr == `A_CONFIG) ||
				(addr == `A_STATUS);
		end
	endfunction

	wire [2:0]  fn       = ir_q[`FN_F];
	wire        reg_sel  = ir_q[`RSEL_B];
	wire [1:0]  cond_select_field = ir_q[`COND_F];
	wire        ret_bit  = ir_q[`RET_B];
	wire [2:0]  shift_fn = ir_q[`SH_F];
	wire        sign_bit = ir_q[`SIGN_B];
	wire        is_step  = (ir_q[`SM_F] == `SM_OPC);
	wire        is_store = (ir_q[`ST_F] == `ST_OPC) &&
		(cond_select_field == `ST_SEL);
	wire        is_add   = (fn == `F_ADD);
	wire        is_sub   = (fn == `F_SUB);
	wire        arith    = is_add | is_sub;

	wire [15:0] shifted_pseudo_reg =
		{math_operand_reg_q[14:0], 1'b0} | shift_remainder_reg_q;
	wire [15:0] opr = reg_sel ? shifted_pseudo_reg : math_operand_reg_q;
	wire        ext = sign_bit ? opr[15] : 1'b0;

	wire [17:0] sum_add = {1'b0, ext_bit_low_q, top_q} + {1'b0, ext, opr};
	wire [17:0] sum_sub = {1'b0, ext_bit_low_q, top_q} +
		{1'b0, ~ext, ~opr} + 18'h00001;
	wire        carry_value = is_add ? sum_add[17] : sum_sub[17];

	reg cond_flag;
	always @* begin
		case (cond_select_field)
			`COND_CARRY:    cond_flag = arith ? carry_value : sign_bit;
			`COND_CARRY_HI: cond_flag = (arith ? carry_value : sign_bit) |
				ext_bit_high_q;
			`COND_PICK:     cond_flag = ir_q[`PICK_B] ? next_q[0] : top_q[0];
			default:      cond_flag = top_q[0] ^ next_q[0];
		endcase
	end

	reg [17:0] w;
	always @* begin
		if (!cond_flag)
			w = {ext_bit_high_q, ext_bit_low_q, top_q};
		else if (is_add)
			w = sum_add;
		else if (is_sub)
			w = sum_sub;
		else
			w = {ext_bit_high_q, ext_bit_low_q, alu16(fn, top_q, opr)};
	end

	// shifter after the alu, same cycle
	reg        sh_hi;
	reg        sh_lo;
	reg [15:0] sh_top;
	reg [15:0] sh_next;
	always @* begin
		sh_next = next_q;
		case (shift_fn)
			3'h1: begin
				sh_hi  = w[16];
				sh_lo  = w[15];
				sh_top = {w[14:0], cond_flag};
			end
			3'h2, 3'h6: begin
				sh_hi  = w[17];
				sh_lo  = w[17];
				sh_top = w[16:1];
			end
			3'h3, 3'h7: begin
				sh_hi  = w[17];
				sh_lo  = w[17];
				sh_top = {cond_flag, w[15:1]};
			end
			3'h5: begin
				sh_hi  = w[16];
				sh_lo  = w[15];
				sh_top = {w[14:0], next_q[15]};
			end
			default: begin
				sh_hi  = w[17];
				sh_lo  = w[16];
				sh_top = w[15:0];
			end
		endcase
		if (shift_fn == 3'h4 || shift_fn == 3'h5)
			sh_next = {next_q[14:0], cond_flag};
		if (shift_fn == 3'h6 || shift_fn == 3'h7)
			sh_next = {w[0], next_q[15:1]};
		// special encoding keeps w17 in the high bit
		if (ir_q == `SPECIAL_OP)
			sh_hi = w[17];
	end

	// store-literal result
	wire [15:0] lit     = {11'h0, ir_q[`LIT_F]};
	wire [15:0] st_top  = alu16(fn, top_q, lit);
	// axi write side: address and data taken in either order
	assign s_axi_awready = !aw_have_q;
	assign s_axi_wready  = !w_have_q;
	assign s_axi_arready = !s_axi_rvalid;
	// commit only while idle so execution never races a write
	wire wr_go = aw_have_q && w_have_q && !s_axi_bvalid &&
		(state_q == S_IDLE);
	wire wr_ok = mapped(aw_addr_q) && (aw_addr_q != `A_STATUS);

	reg [31:0] rd_val;
	always @* begin
		case (s_axi_araddr)
			`A_INSTR:  rd_val = {16'h0000, ir_q};
			`A_TOP:    rd_val = {16'h0000, top_q};
			`A_NEXT:   rd_val = {16'h0000, next_q};
			`A_MATH:   rd_val = {16'h0000, math_operand_reg_q};
			`A_REM:    rd_val = {16'h0000, shift_remainder_reg_q};
			`A_CONFIG: rd_val = {30'h0, ext_bit_high_q,
				ext_bit_low_q};
			`A_STATUS: rd_val = {30'h0, cond_flag_q,
				state_q != S_IDLE};
			default:   rd_val = 32'h00000000;
		endcase
	end

	always @(posedge sys_clk) begin
		if (!rst_b) begin
			state_q               <= S_IDLE;
			ir_q                  <= 16'h0000;
			top_q                 <= 16'h0000;
			next_q                <= 16'h0000;
			math_operand_reg_q    <= 16'h0000;
			shift_remainder_reg_q <= 16'h0000;
			ext_bit_low_q         <= 1'b0;
			ext_bit_high_q        <= 1'b0;
			cond_flag_q           <= 1'b0;
			aw_have_q             <= 1'b0;
			aw_addr_q             <= 8'h00;
			w_have_q              <= 1'b0;
			w_data_q              <= 32'h00000000;
			s_axi_bvalid          <= 1'b0;
			s_axi_bresp           <= `RESP_OK;
			s_axi_rvalid          <= 1'b0;
			s_axi_rresp           <= `RESP_OK;
			s_axi_rdata           <= 32'h00000000;
			pstack_pop            <= 1'b0;
			mem_we                <= 1'b0;
			mem_addr              <= 16'h0000;
			mem_wdata             <= 16'h0000;
			ret_pulse             <= 1'b0;
		end else if (ce) begin
			pstack_pop <= 1'b0;
			mem_we     <= 1'b0;
			ret_pulse  <= 1'b0;
			if (s_axi_awvalid && !aw_have_q) begin
				aw_have_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !w_have_q) begin
				w_have_q <= 1'b1;
				w_data_q <= s_axi_wdata;
			end
			if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (s_axi_arvalid && !s_axi_rvalid) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_val;
				s_axi_rresp  <= mapped(s_axi_araddr) ? `RESP_OK :
					`RESP_ERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
			if (wr_go) begin
				aw_have_q    <= 1'b0;
				w_have_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_ok ? `RESP_OK : `RESP_ERR;
				case (aw_addr_q)
					`A_INSTR: begin
						ir_q    <= w_data_q[15:0];
						state_q <= S_EXEC;
					end
					`A_TOP:  top_q <= w_data_q[15:0];
					`A_NEXT: next_q <= w_data_q[15:0];
					`A_MATH: math_operand_reg_q <= w_data_q[15:0];
					`A_REM:  shift_remainder_reg_q <= w_data_q[15:0];
					`A_CONFIG: begin
						ext_bit_low_q  <= w_data_q[0];
						ext_bit_high_q <= w_data_q[1];
					end
					default: ;
				endcase
			end
			case (state_q)
				S_EXEC: begin
					state_q <= S_IDLE;
					ret_pulse <= (is_step || is_store) && ret_bit;
					if (is_step) begin
						cond_flag_q <= cond_flag;
						top_q  <= sh_top;
						next_q <= sh_next;
						// low bit only with alu or shift
						if (fn != `F_NOP || shift_fn != 3'h0)
							ext_bit_low_q <= sh_lo;
						if (arith)
							ext_bit_high_q <= sh_hi;
						if (reg_sel && cond_flag) begin
							math_operand_reg_q <= math_operand_reg_q |
								shift_remainder_reg_q;
							shift_remainder_reg_q <=
								{1'b0, shift_remainder_reg_q[15:1]};
						end
					end else if (is_store) begin
						// write next at top, then top
						mem_we    <= 1'b1;
						mem_addr  <= top_q;
						mem_wdata <= next_q;
						top_q     <= st_top;
						state_q   <= S_ST2;
					end
					// reserved and other patterns: no effect
				end
				S_ST2: begin
					state_q <= S_IDLE;
					if (ir_q[`RSEL_B]) begin
						next_q     <= pstack_data;
						pstack_pop <= 1'b1;
					end
				end
				S_IDLE:  ;
				default: state_q <= S_IDLE;
			endcase
		end
	end
endmodule

/* rtl/step_math_defines.vh */
// Purpose: constants for the step-math datapath
// Assumes: AXI4-Lite byte addresses, 32-bit data
// Notes:   definitions only
`ifndef STEP_MATH_DEFINES_VH
`define STEP_MATH_DEFINES_VH

// register byte offsets
`define A_INSTR     8'h00
`define A_TOP       8'h04
`define A_NEXT      8'h08
`define A_MATH      8'h0c
`define A_REM       8'h10
`define A_CONFIG    8'h14
`define A_STATUS    8'h18

// opcode fields
`define SM_OPC      4'ha
`define ST_OPC      3'h7
`define ST_SEL      2'h3
`define SPECIAL_OP  16'ha057
`define RSVD_OPC    3'h6

// opcode field positions
`define SM_F        15:12
`define ST_F        15:13
`define FN_F        11:9
`define RSEL_B      8
`define COND_F      7:6
`define RET_B       5
`define LIT_F       4:0
`define SH_F        3:1
`define PICK_B      3
`define SIGN_B      0

// alu functions
`define F_NOP       3'h0
`define F_AND       3'h1
`define F_SUB       3'h2
`define F_OR        3'h3
`define F_ADD       3'h4
`define F_XOR       3'h5
`define F_ANDN      3'h6
`define F_LOAD      3'h7

// condition field codes
`define COND_CARRY    2'h0
`define COND_CARRY_HI 2'h1
`define COND_PICK     2'h2
`define COND_PARITY   2'h3

// axi responses
`define RESP_OK     2'h0
`define RESP_ERR    2'h2

`endif

/* verification/mem_model.sv */
// Purpose: data memory and parameter stack beside the datapath
// Assumes: one strobe per store and per pop
// Notes:   stack values count up so each pop is distinct
module mem_model (
	input  wire         sys_clk,
	input  wire         mem_we,
	input  wire  [15:0] mem_addr,
	input  wire  [15:0] mem_wdata,
	input  wire         pstack_pop,
	output logic [15:0] pstack_data
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] mem [0:65535];
	logic [15:0] depth_q = 16'h0000;
	assign pstack_data = 16'h5a00 + depth_q;
	always @(posedge sys_clk) begin
		if (mem_we)
			mem[mem_addr] <= mem_wdata;
		if (pstack_pop)
			depth_q <= depth_q + 16'h0001;
	end
endmodule

/* verification/step_math_props.sv */
// Purpose: port assertions for the datapath
// Assumes: ce held high
// Notes:   bound at the foot of this file
module step_math_props (
	input wire        sys_clk,
	input wire        rst_b,
	input wire        s_axi_awvalid,
	input wire        s_axi_awready,
	input wire [1:0]  s_axi_bresp,
	input wire        s_axi_bvalid,
	input wire        s_axi_bready,
	input wire        s_axi_arvalid,
	input wire        s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire        s_axi_rvalid,
	input wire        s_axi_rready,
	input wire        pstack_pop,
	input wire        mem_we,
	input wire        ret_pulse
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	a_we_pulse: assert property (mem_we |=> !mem_we)
		else $error("store strobe too long");
	a_pop_after: assert property (pstack_pop |-> $past(mem_we))
		else $error("pop without store one cycle before");
	a_pop_pulse: assert property (pstack_pop |=> !pstack_pop)
		else $error("pop strobe too long");
	a_ret_pulse: assert property (ret_pulse |=> !ret_pulse)
		else $error("return strobe too long");
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid)
		else $error("read answer late");
	a_rvalid_cause: assert property ($rose(s_axi_rvalid)
		|-> $past(s_axi_arvalid && s_axi_arready))
		else $error("read data without a read request");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready
		|-> ##[1:4] s_axi_bvalid)
		else $error("write answer late");
	cover property (mem_we);
	cover property (pstack_pop);
	cover property (ret_pulse);
endmodule
bind step_math_datapath step_math_props step_math_props_inst (.*);

/* verification/test_step_math_datapath.sv */
// Purpose: directed checks of the datapath over axi4-lite
// Assumes: ce held high, full-word strobes
// Notes:   expected values worked by hand from opcode fields
`include "step_math_defines.vh"
module test_step_math_datapath;
	timeunit 1ns;
	timeprecision 1ps;
	logic        sys_clk, rst_b, ce;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata;
	logic [3:0]  s_axi_wstrb;
	logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic        s_axi_arvalid, s_axi_rready;
	wire         s_axi_awready, s_axi_wready, s_axi_bvalid;
	wire         s_axi_arready, s_axi_rvalid;
	wire  [1:0]  s_axi_bresp, s_axi_rresp;
	wire  [31:0] s_axi_rdata;
	wire  [15:0] pstack_data, mem_addr, mem_wdata;
	wire         pstack_pop, mem_we, ret_pulse;
	int          err_count, cmp_count, cyc, nwe, npop, nret;
	step_math_datapath step_math_datapath_inst (.*);
	mem_model mem_model_inst (.*);
	task automatic print_verdict();
		if (err_count == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d,
		input logic [1:0] er);
		bit ta;
		bit tw;
		ta = 0;
		tw = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= {16'h0000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (!(ta && tw)) begin
			@(posedge sys_clk);
			if (s_axi_awvalid && s_axi_awready)
				ta = 1;
			if (s_axi_wvalid && s_axi_wready)
				tw = 1;
			s_axi_awvalid <= !ta;
			s_axi_wvalid <= !tw;
		end
		s_axi_bready <= 1'b1;
		do
			@(posedge sys_clk);
		while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		chk({30'h0, s_axi_bresp}, {30'h0, er});
	endtask
	task automatic rc(input logic [7:0] a, input logic [15:0] e,
		input logic [1:0] er);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
			@(posedge sys_clk);
		while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do
			@(posedge sys_clk);
		while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		chk({16'h0, s_axi_rdata[15:0]}, {16'h0, e});
		chk({30'h0, s_axi_rresp}, {30'h0, er});
	endtask
	task automatic ex(input logic [15:0] op);
		wr(`A_INSTR, op, `RESP_OK);
		// store finishes two cycles after commit
		repeat (3) @(posedge sys_clk);
	endtask
	task automatic mc(input logic [15:0] a, input logic [15:0] e);
		chk({16'h0, mem_model_inst.mem[a]}, {16'h0, e});
	endtask
	initial begin
		sys_clk = 0;
		forever #10 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cyc++;
		nwe += (mem_we === 1'b1);
		npop += (pstack_pop === 1'b1);
		nret += (ret_pulse === 1'b1);
		if (cyc == 4000) begin
			err_count++;
			print_verdict();
		end
	end
	initial begin
		{rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 0;
		{s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 0;
		s_axi_wdata = 0;
		s_axi_wstrb = 4'hf;
		ce = 1;
		repeat (16) @(posedge sys_clk);
		rst_b <= 1'b1;
		rc(`A_CONFIG, 0, `RESP_OK);
		rc(8'h1c, 0, `RESP_ERR);
		wr(`A_STATUS, 1, `RESP_ERR);
		wr(`A_TOP, 16'h00f0, `RESP_OK);
		wr(`A_MATH, 16'h0ff0, `RESP_OK);
		wr(`A_CONFIG, 3, `RESP_OK);
		ex(16'haa00);
		rc(`A_TOP, 16'h00f0, `RESP_OK);
		ex(16'haa01);
		rc(`A_TOP, 16'h0f00, `RESP_OK);
		rc(`A_CONFIG, 3, `RESP_OK);
		wr(`A_TOP, 16'hffff, `RESP_OK);
		wr(`A_MATH, 16'h0001, `RESP_OK);
		wr(`A_CONFIG, 1, `RESP_OK);
		ex(16'ha800);
		rc(`A_TOP, 16'h0000, `RESP_OK);
		rc(`A_CONFIG, 2, `RESP_OK);
		wr(`A_TOP, 16'h8001, `RESP_OK);
		wr(`A_CONFIG, 0, `RESP_OK);
		ex(16'ha003);
		rc(`A_TOP, 16'h0003, `RESP_OK);
		rc(`A_CONFIG, 1, `RESP_OK);
		wr(`A_MATH, 16'h1234, `RESP_OK);
		wr(`A_REM, 16'h0001, `RESP_OK);
		ex(16'haf01);
		rc(`A_TOP, 16'h2469, `RESP_OK);
		rc(`A_MATH, 16'h1235, `RESP_OK);
		rc(`A_REM, 16'h0000, `RESP_OK);
		ex(16'ha020);
		chk(nret, 1);
		rc(`A_TOP, 16'h2469, `RESP_OK);
		wr(`A_TOP, 16'h0040, `RESP_OK);
		wr(`A_NEXT, 16'hbeef, `RESP_OK);
		ex(16'heed5);
		mc(16'h0040, 16'hbeef);
		rc(`A_TOP, 16'h0015, `RESP_OK);
		rc(`A_NEXT, 16'hbeef, `RESP_OK);
		chk(npop, 0);
		wr(`A_TOP, 16'h0041, `RESP_OK);
		wr(`A_NEXT, 16'h1111, `RESP_OK);
		ex(16'hefca);
		mc(16'h0041, 16'h1111);
		rc(`A_TOP, 16'h000a, `RESP_OK);
		rc(`A_NEXT, 16'h5a00, `RESP_OK);
		wr(`A_TOP, 16'h0100, `RESP_OK);
		wr(`A_NEXT, 16'h2222, `RESP_OK);
		ex(16'he9c3);
		mc(16'h0100, 16'h2222);
		rc(`A_TOP, 16'h0103, `RESP_OK);
		rc(`A_NEXT, 16'h5a01, `RESP_OK);
		ex(16'hc000);
		rc(`A_TOP, 16'h0103, `RESP_OK);
		chk(nwe, 3);
		chk(npop, 2);
		wr(`A_TOP, 16'h0001, `RESP_OK);
		wr(`A_NEXT, 16'h0000, `RESP_OK);
		ex(16'haec8);
		rc(`A_TOP, 16'h1235, `RESP_OK);
		rc(`A_NEXT, 16'h0001, `RESP_OK);
		print_verdict();
	end
endmodule
